//--- design/cep_core_exception_prioritizer.sv
// exception recognition, priority selection, debug mode and power-down entry
module cep_core_exception_prioritizer
  import cep_pkg::*;
#(
  parameter int IRQ_W = 8
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  // reset sources, pin and power-on
  input wire logic master_clear_pin,
  input wire logic por_event,
  // debug requests
  input wire logic single_step,
  input wire logic debug_interrupt_input,
  input wire logic debug_break_request_bit,
  // non-maskable pin
  input wire logic nmi_in,
  // interrupt lines and their masks
  input wire logic [IRQ_W-1:0] irq_req,
  input wire logic [IRQ_W-1:0] irq_mask,
  // fetch stage faults and breaks
  input wire logic instr_break,
  input wire logic fetch_misaligned,
  input wire logic fetch_protected,
  input wire logic fetch_bus_fault,
  // execute stage causes
  input wire logic exec_debug_bp_opcode,
  input wire logic exec_syscall,
  input wire logic exec_break,
  input wire logic exec_reserved,
  input wire logic exec_cop_disabled,
  input wire logic exec_ext_disabled,
  input wire logic arith_overflow,
  input wire logic trap_cond_true,
  // data side matches and faults
  input wire logic data_addr_match,
  input wire logic store_value_match,
  input wire logic load_misaligned,
  input wire logic load_protected,
  input wire logic store_misaligned,
  input wire logic store_protected,
  input wire logic data_bus_fault,
  input wire logic load_data_match,
  // returns, sleep and wake
  input wire logic handler_return,
  input wire logic debug_return_instr,
  input wire logic exec_sleep,
  input wire logic wake_event,
  // serial debug port from the probe
  input wire logic tap_tck,
  input wire logic tap_tdi,
  input wire logic tap_shift,
  input wire logic tap_update,
  // serial debug port back to the probe
  output logic tap_tdo,
  output logic [CEP_DBG_SEL_W-1:0] dbg_reg_select,
  // taken exception report
  output logic exc_take,
  output logic [4:0] exc_code,
  output logic [CEP_NUM_EXC-1:0] exc_pending,
  // core mode, decoded from state
  output logic in_handler,
  output logic debug_mode,
  output logic power_down
);

  logic [CEP_NUM_EXC-1:0] req;
  logic [4:0] next_code;
  logic any_req;
  logic irq_active;
  logic debug_kind;
  // synchroniser stages, one chain per pin
  logic nmi_s1;
  logic nmi_s2;
  logic nmi_s3;
  logic debug_int_s1;
  logic debug_int_s2;
  logic debug_int_s3;
  logic master_clear_pin_s1;
  logic master_clear_pin_s2;
  logic master_clear_pin_s3;
  logic tck_s1;
  logic tck_s2;
  logic tck_s3;
  // filtered pin levels
  logic nmi_lvl;
  logic debug_int_lvl;
  logic master_clear_pin_lvl;
  logic tck_prev;
  logic tck_rise;
  logic [CEP_DBG_SEL_W-1:0] tap_shreg;
  cep_state_t state;

  // nmi pin: three stages, only the second stage reads the first
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      nmi_s1 <= 1'b0;
      nmi_s2 <= 1'b0;
      nmi_s3 <= 1'b0;
    end else begin
      nmi_s1 <= nmi_in;
      nmi_s2 <= nmi_s1;
      nmi_s3 <= nmi_s2;
    end
  end

  // debug interrupt pin: three stages
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      debug_int_s1 <= 1'b0;
      debug_int_s2 <= 1'b0;
      debug_int_s3 <= 1'b0;
    end else begin
      debug_int_s1 <= debug_interrupt_input;
      debug_int_s2 <= debug_int_s1;
      debug_int_s3 <= debug_int_s2;
    end
  end

  // master clear pin: three stages
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      master_clear_pin_s1 <= 1'b0;
      master_clear_pin_s2 <= 1'b0;
      master_clear_pin_s3 <= 1'b0;
    end else begin
      master_clear_pin_s1 <= master_clear_pin;
      master_clear_pin_s2 <= master_clear_pin_s1;
      master_clear_pin_s3 <= master_clear_pin_s2;
    end
  end

  // probe clock pin: three stages; tck rests low so no false edge after reset
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tck_s1 <= 1'b0;
      tck_s2 <= 1'b0;
      tck_s3 <= 1'b0;
    end else begin
      tck_s1 <= tap_tck;
      tck_s2 <= tck_s1;
      tck_s3 <= tck_s2;
    end
  end

  // nmi level moves only when stages two and three agree, dropping glitches
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      nmi_lvl <= 1'b0;
    end else if (nmi_s2 == nmi_s3) begin
      nmi_lvl <= nmi_s3;
    end
  end

  // debug interrupt level, same agreement filter
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      debug_int_lvl <= 1'b0;
    end else if (debug_int_s2 == debug_int_s3) begin
      debug_int_lvl <= debug_int_s3;
    end
  end

  // master clear level; costs latency, but a spike never resets the core
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      master_clear_pin_lvl <= 1'b0;
    end else if (master_clear_pin_s2 == master_clear_pin_s3) begin
      master_clear_pin_lvl <= master_clear_pin_s3;
    end
  end

  // filtered tck level, also the previous value for edge detection
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tck_prev <= 1'b0;
    end else if (tck_s2 == tck_s3) begin
      tck_prev <= tck_s3;
    end
  end

  // one-cycle pulse on an agreed rising tck
  assign tck_rise = (tck_s2 == tck_s3) && tck_s3 && !tck_prev;

  // request vector, one bit per exception kind
  assign irq_active = |(irq_req & ~irq_mask);
  always_comb begin
    req = '0;
    req[CEP_IDX_RESET] = master_clear_pin_lvl | por_event;
    req[CEP_IDX_SINGLE_STEP] = single_step;
    req[CEP_IDX_DEBUG_INT] = debug_int_lvl | debug_break_request_bit;
    req[CEP_IDX_NMI] = nmi_lvl;
    req[CEP_IDX_INTERRUPT] = irq_active;
    req[CEP_IDX_INSTR_BREAK] = instr_break;
    req[CEP_IDX_FETCH_ADDR_ERR] = fetch_misaligned | fetch_protected;
    req[CEP_IDX_FETCH_BUS_ERR] = fetch_bus_fault;
    req[CEP_IDX_DEBUG_BP_INSTR] = exec_debug_bp_opcode;
    req[CEP_IDX_SYSCALL] = exec_syscall;
    req[CEP_IDX_SOFTWARE_BP] = exec_break;
    req[CEP_IDX_RESERVED_INSTR] = exec_reserved;
    req[CEP_IDX_COP_UNUSABLE] = exec_cop_disabled;
    req[CEP_IDX_EXT_UNUSABLE] = exec_ext_disabled;
    req[CEP_IDX_OVERFLOW] = arith_overflow;
    req[CEP_IDX_TRAP] = trap_cond_true;
    req[CEP_IDX_DATA_BREAK] = data_addr_match | store_value_match;
    req[CEP_IDX_LOAD_ADDR_ERR] = load_misaligned | load_protected;
    req[CEP_IDX_STORE_ADDR_ERR] = store_misaligned | store_protected;
    req[CEP_IDX_DATA_BUS_ERR] = data_bus_fault;
    req[CEP_IDX_LOAD_DATA_BREAK] = load_data_match;
  end

  // any request at all, whatever its rank
  assign any_req = |req;

  // fixed priority chain, reset first; earlier branches shadow later ones
  always_comb begin
    if (req[CEP_IDX_RESET]) next_code = 5'(CEP_IDX_RESET);
    else if (req[CEP_IDX_SINGLE_STEP]) next_code = 5'(CEP_IDX_SINGLE_STEP);
    else if (req[CEP_IDX_DEBUG_INT]) next_code = 5'(CEP_IDX_DEBUG_INT);
    else if (req[CEP_IDX_NMI]) next_code = 5'(CEP_IDX_NMI);
    else if (req[CEP_IDX_INTERRUPT]) next_code = 5'(CEP_IDX_INTERRUPT);
    else if (req[CEP_IDX_INSTR_BREAK]) next_code = 5'(CEP_IDX_INSTR_BREAK);
    else if (req[CEP_IDX_FETCH_ADDR_ERR]) next_code = 5'(CEP_IDX_FETCH_ADDR_ERR);
    else if (req[CEP_IDX_FETCH_BUS_ERR]) next_code = 5'(CEP_IDX_FETCH_BUS_ERR);
    else if (req[CEP_IDX_DEBUG_BP_INSTR]) next_code = 5'(CEP_IDX_DEBUG_BP_INSTR);
    else if (req[CEP_IDX_SYSCALL]) next_code = 5'(CEP_IDX_SYSCALL);
    else if (req[CEP_IDX_SOFTWARE_BP]) next_code = 5'(CEP_IDX_SOFTWARE_BP);
    else if (req[CEP_IDX_RESERVED_INSTR]) next_code = 5'(CEP_IDX_RESERVED_INSTR);
    else if (req[CEP_IDX_COP_UNUSABLE]) next_code = 5'(CEP_IDX_COP_UNUSABLE);
    else if (req[CEP_IDX_EXT_UNUSABLE]) next_code = 5'(CEP_IDX_EXT_UNUSABLE);
    else if (req[CEP_IDX_OVERFLOW]) next_code = 5'(CEP_IDX_OVERFLOW);
    else if (req[CEP_IDX_TRAP]) next_code = 5'(CEP_IDX_TRAP);
    else if (req[CEP_IDX_DATA_BREAK]) next_code = 5'(CEP_IDX_DATA_BREAK);
    else if (req[CEP_IDX_LOAD_ADDR_ERR]) next_code = 5'(CEP_IDX_LOAD_ADDR_ERR);
    else if (req[CEP_IDX_STORE_ADDR_ERR]) next_code = 5'(CEP_IDX_STORE_ADDR_ERR);
    else if (req[CEP_IDX_DATA_BUS_ERR]) next_code = 5'(CEP_IDX_DATA_BUS_ERR);
    else if (req[CEP_IDX_LOAD_DATA_BREAK]) next_code = 5'(CEP_IDX_LOAD_DATA_BREAK);
    else next_code = CEP_CODE_NONE;
  end

  // single step, debug interrupt and every break except the software break lead into debug mode
  always_comb begin
    debug_kind = 1'b0;
    case (next_code)
      5'(CEP_IDX_SINGLE_STEP), 5'(CEP_IDX_DEBUG_INT), 5'(CEP_IDX_INSTR_BREAK),
      5'(CEP_IDX_DEBUG_BP_INSTR), 5'(CEP_IDX_DATA_BREAK),
      5'(CEP_IDX_LOAD_DATA_BREAK): debug_kind = 1'b1;
      default: debug_kind = 1'b0;
    endcase
  end

  // core state; all state sits in flops so a stopped clock loses nothing
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= CEP_ST_RUN;
    end else begin
      case (state)
        CEP_ST_RUN: begin
          if (any_req) begin
            // one exception per entry; the rest wait for the return
            if (debug_kind) state <= CEP_ST_DEBUG;
            else if (next_code != 5'(CEP_IDX_RESET)) state <= CEP_ST_HANDLER;
          end else if (exec_sleep) begin
            state <= CEP_ST_SLEEP;
          end
        end
        CEP_ST_HANDLER: begin
          if (req[CEP_IDX_RESET]) state <= CEP_ST_RUN;
          else if (handler_return) state <= CEP_ST_RUN;
        end
        CEP_ST_DEBUG: begin
          // only reset or the debug return leaves debug mode
          if (req[CEP_IDX_RESET]) state <= CEP_ST_RUN;
          else if (debug_return_instr) state <= CEP_ST_RUN;
        end
        CEP_ST_SLEEP: begin
          if (any_req || wake_event) state <= CEP_ST_RUN;
        end
        default: state <= CEP_ST_RUN;
      endcase
    end
  end

  // taken exception report, registered
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      exc_take <= 1'b0;
      exc_code <= CEP_CODE_NONE;
      exc_pending <= '0;
    end else begin
      // pending copies the whole request vector (filtered pins, masked interrupt), taken or not
      exc_pending <= req;
      // reset is always taken, even from inside a handler
      if ((state == CEP_ST_RUN && any_req) || req[CEP_IDX_RESET]) begin
        exc_take <= 1'b1;
        exc_code <= next_code;
      end else begin
        exc_take <= 1'b0;
        exc_code <= CEP_CODE_NONE;
      end
    end
  end

  // mode outputs decoded straight from the state flop
  assign in_handler = (state == CEP_ST_HANDLER);
  assign debug_mode = (state == CEP_ST_DEBUG);
  assign power_down = (state == CEP_ST_SLEEP);

  // serial debug instruction shift, sampled on filtered tck rising edges
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tap_shreg <= '0;
      dbg_reg_select <= '0;
      tap_tdo <= 1'b0;
    end else if (tck_rise) begin
      if (tap_shift) begin
        tap_shreg <= {tap_tdi, tap_shreg[CEP_DBG_SEL_W-1:1]};
        tap_tdo <= tap_shreg[0];
      end else if (tap_update) begin
        dbg_reg_select <= tap_shreg;
      end
    end
  end

endmodule : cep_core_exception_prioritizer

//--- design/cep_pkg.sv
// shared constants and types for the core exception prioritizer
package cep_pkg;
  // exception request indices, highest priority first
  localparam int CEP_NUM_EXC = 21;
  localparam int CEP_IDX_RESET = 0;
  localparam int CEP_IDX_SINGLE_STEP = 1;
  localparam int CEP_IDX_DEBUG_INT = 2;
  localparam int CEP_IDX_NMI = 3;
  localparam int CEP_IDX_INTERRUPT = 4;
  localparam int CEP_IDX_INSTR_BREAK = 5;
  localparam int CEP_IDX_FETCH_ADDR_ERR = 6;
  localparam int CEP_IDX_FETCH_BUS_ERR = 7;
  localparam int CEP_IDX_DEBUG_BP_INSTR = 8;
  localparam int CEP_IDX_SYSCALL = 9;
  localparam int CEP_IDX_SOFTWARE_BP = 10;
  localparam int CEP_IDX_RESERVED_INSTR = 11;
  localparam int CEP_IDX_COP_UNUSABLE = 12;
  localparam int CEP_IDX_EXT_UNUSABLE = 13;
  localparam int CEP_IDX_OVERFLOW = 14;
  localparam int CEP_IDX_TRAP = 15;
  localparam int CEP_IDX_DATA_BREAK = 16;
  localparam int CEP_IDX_LOAD_ADDR_ERR = 17;
  localparam int CEP_IDX_STORE_ADDR_ERR = 18;
  localparam int CEP_IDX_DATA_BUS_ERR = 19;
  localparam int CEP_IDX_LOAD_DATA_BREAK = 20;
  // code driven when nothing is taken
  localparam logic [4:0] CEP_CODE_NONE = 5'h1F;
  // debug register selector width on the test access port
  localparam int CEP_DBG_SEL_W = 4;
  // core state
  typedef enum logic [1:0] {
    CEP_ST_RUN,
    CEP_ST_HANDLER,
    CEP_ST_DEBUG,
    CEP_ST_SLEEP
  } cep_state_t;
endpackage : cep_pkg

//--- verification/cep_checker_assertions.sv
// concurrent checks on the prioritizer ports
module cep_checker
  import cep_pkg::*;
#(
  parameter int IRQ_W = 8
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic por_event,
  input wire logic exec_syscall,
  input wire logic arith_overflow,
  input wire logic exec_sleep,
  input wire logic debug_return_instr,
  input wire logic [IRQ_W-1:0] irq_req,
  input wire logic [IRQ_W-1:0] irq_mask,
  input wire logic exc_take,
  input wire logic [4:0] exc_code,
  input wire logic in_handler,
  input wire logic debug_mode,
  input wire logic power_down
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // reset outranks everything, in any state
  reset_first_a: assert property (por_event |=> exc_take && exc_code == 5'h00)
    else $error("reset not taken first");
  syscall_cause_a: assert property (exc_take && exc_code == 5'h09 |-> $past(exec_syscall))
    else $error("syscall code without cause");
  // a masked line must never be the cause
  irq_unmasked_a: assert property (exc_take && exc_code == 5'h04
    |-> |($past(irq_req) & ~$past(irq_mask)))
    else $error("interrupt taken while masked");
  ovf_cause_a: assert property (exc_take && exc_code == 5'h0E |-> $past(arith_overflow))
    else $error("overflow code without cause");
  sleep_entry_a: assert property ($rose(power_down) |-> $past(exec_sleep))
    else $error("power-down without sleep");
  debug_exit_a: assert property ($fell(debug_mode)
    |-> $past(debug_return_instr) || exc_code == 5'h00)
    else $error("debug mode left early");
  step_debug_a: assert property (exc_take && exc_code == 5'h01 |-> debug_mode)
    else $error("single step outside debug");
  // once in a handler only reset may be reported
  one_at_time_a: assert property (in_handler && $past(in_handler) && exc_take
    |-> exc_code == 5'h00)
    else $error("second exception in handler");
endmodule : cep_checker

//--- verification/cep_far_side.sv
// debug probe model on the serial test access port
module cep_far_side (
  input wire logic sys_clk,
  output logic tap_tck = 1'b0,
  output logic tap_tdi = 1'b0,
  output logic tap_shift = 1'b0,
  output logic tap_update = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  // slow tck pulse, long against the pin filter; tck rests low
  task tick;
    repeat (6) @(posedge sys_clk);
    tap_tck <= 1'b1;
    repeat (6) @(posedge sys_clk);
    tap_tck <= 1'b0;
  endtask : tick
  // selector goes out lsb first, then an update pulse loads it
  task send_sel(input logic [3:0] v);
    @(posedge sys_clk);
    tap_shift <= 1'b1;
    for (int b = 0; b < 4; b++) begin
      tap_tdi <= v[b];
      tick();
    end
    tap_shift <= 1'b0;
    tap_tdi <= ~v[3]; // released line shows no stale bit
    tap_update <= 1'b1;
    tick();
    tap_update <= 1'b0;
  endtask : send_sel
endmodule : cep_far_side

//--- verification/testbench.sv
// self-checking bench for the exception prioritizer
module testbench import cep_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic alt = 1'b0;
  logic [20:0] req = '0;
  logic [7:0] irq = 8'h00;
  logic [7:0] irq_mask = 8'h00;
  logic handler_return = 1'b0;
  logic debug_return_instr = 1'b0;
  logic exec_sleep = 1'b0;
  logic wake_event = 1'b0;
  logic tap_tck, tap_tdi, tap_shift, tap_update, tap_tdo;
  logic exc_take, in_handler, debug_mode, power_down;
  logic [3:0] dbg_reg_select;
  logic [4:0] exc_code;
  logic [20:0] exc_pending;
  logic [31:0] seed = 32'h3B40;
  int errors = 0;
  int n_compared = 0;
  int cycles = 0;
  always #5 sys_clk = ~sys_clk;
  // alt picks which of two sources raises a shared exception kind
  cep_core_exception_prioritizer #(.IRQ_W(8)) cep_core_exception_prioritizer_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .master_clear_pin(req[0] & alt),
    .por_event(req[0] & ~alt), .single_step(req[1]), .debug_interrupt_input(req[2] & alt),
    .debug_break_request_bit(req[2] & ~alt), .nmi_in(req[3]), .irq_req(irq),
    .irq_mask(irq_mask), .instr_break(req[5]), .fetch_misaligned(req[6] & alt),
    .fetch_protected(req[6] & ~alt), .fetch_bus_fault(req[7]), .exec_debug_bp_opcode(req[8]),
    .exec_syscall(req[9]), .exec_break(req[10]), .exec_reserved(req[11]),
    .exec_cop_disabled(req[12]), .exec_ext_disabled(req[13]), .arith_overflow(req[14]),
    .trap_cond_true(req[15]), .data_addr_match(req[16] & alt),
    .store_value_match(req[16] & ~alt), .load_misaligned(req[17] & alt),
    .load_protected(req[17] & ~alt), .store_misaligned(req[18] & alt),
    .store_protected(req[18] & ~alt), .data_bus_fault(req[19]), .load_data_match(req[20]),
    .handler_return(handler_return), .debug_return_instr(debug_return_instr),
    .exec_sleep(exec_sleep), .wake_event(wake_event), .tap_tck(tap_tck), .tap_tdi(tap_tdi),
    .tap_shift(tap_shift), .tap_update(tap_update), .tap_tdo(tap_tdo),
    .dbg_reg_select(dbg_reg_select), .exc_take(exc_take), .exc_code(exc_code),
    .exc_pending(exc_pending), .in_handler(in_handler), .debug_mode(debug_mode),
    .power_down(power_down));
  cep_far_side cep_far_side_inst (.sys_clk(sys_clk), .tap_tck(tap_tck), .tap_tdi(tap_tdi),
    .tap_shift(tap_shift), .tap_update(tap_update));
  task chk(input string what, input logic [4:0] seen, input logic [4:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  function logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // lowest index wins
  function logic [4:0] top_req(input logic [20:0] v);
    top_req = CEP_CODE_NONE;
    for (int i = 20; i >= 0; i--) begin
      if (v[i]) top_req = 5'(i);
    end
  endfunction : top_req
  function logic dbg_kind(input int i);
    return i inside {1, 2, 5, 8, 16, 20};
  endfunction : dbg_kind
  task wait_take;
    for (int k = 0; k < 12 && exc_take !== 1'b1; k++) @(negedge sys_clk);
  endtask : wait_take
  // drop requests, let filtered pins drain, then return from any handler
  task settle;
    @(posedge sys_clk);
    req <= '0;
    irq <= 8'h00;
    repeat (8) @(posedge sys_clk);
    handler_return <= 1'b1;
    debug_return_instr <= 1'b1;
    @(posedge sys_clk);
    handler_return <= 1'b0;
    debug_return_instr <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask : settle
  task tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      errors++;
      tally_and_finish();
    end
  end
  initial begin
    logic [20:0] v;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(negedge sys_clk);
    chk("idle code", exc_code, CEP_CODE_NONE);
    for (int i = 0; i < 21; i++) begin
      seed = lfsr(seed);
      v = (seed[20:0] & ~((21'h1 << i) - 21'h1)) | (21'h1 << i);
      // slow filtered pins on top would let lower sync ones win first
      if (i == 3 || (i < 3 && seed[31])) v = 21'h1 << i;
      @(posedge sys_clk);
      req <= v;
      alt <= seed[31];
      irq <= v[4] ? 8'h01 << seed[23:21] : 8'h00;
      wait_take();
      chk("exc_code", exc_code, top_req(v));
      if (i > 0) chk("debug_mode", 5'(debug_mode), 5'(dbg_kind(i)));
      chk("pending top", 5'(exc_pending[i]), 5'h01);
      settle();
      $display("priority test %0d done", i);
    end
    @(posedge sys_clk);
    irq_mask <= 8'hFF;
    irq <= 8'h5A;
    repeat (6) @(negedge sys_clk);
    chk("masked take", 5'(exc_take), 5'h00);
    @(posedge sys_clk);
    irq_mask <= 8'hF7;
    wait_take();
    chk("unmasked code", exc_code, 5'h04);
    settle();
    $display("mask test done");
    @(posedge sys_clk);
    req <= 21'h200;
    wait_take();
    @(posedge sys_clk);
    req <= 21'h400;
    repeat (4) @(negedge sys_clk);
    chk("held off", 5'(exc_take), 5'h00);
    @(posedge sys_clk);
    handler_return <= 1'b1;
    @(posedge sys_clk);
    handler_return <= 1'b0;
    wait_take();
    chk("after return", exc_code, 5'h0A);
    settle();
    $display("pending test done");
    @(posedge sys_clk);
    exec_sleep <= 1'b1;
    @(posedge sys_clk);
    exec_sleep <= 1'b0;
    @(negedge sys_clk);
    chk("power_down", 5'(power_down), 5'h01);
    @(posedge sys_clk);
    wake_event <= 1'b1;
    @(posedge sys_clk);
    wake_event <= 1'b0;
    @(negedge sys_clk);
    chk("woken", 5'(power_down), 5'h00);
    $display("sleep test done");
    seed = lfsr(seed);
    cep_far_side_inst.send_sel(seed[3:0]);
    repeat (8) @(negedge sys_clk);
    chk("selector", {1'b0, dbg_reg_select}, {1'b0, seed[3:0]});
    v[3:0] = seed[3:0];
    seed = lfsr(seed);
    cep_far_side_inst.send_sel(seed[3:0]);
    repeat (8) @(negedge sys_clk);
    chk("shifted out", 5'(tap_tdo), 5'(v[3]));
    chk("selector again", {1'b0, dbg_reg_select}, {1'b0, seed[3:0]});
    $display("probe test done");
    tally_and_finish();
  end
endmodule : testbench
bind cep_core_exception_prioritizer cep_checker #(.IRQ_W(IRQ_W)) cep_checker_inst (.*);
